//--- common/fcsu_pkg.sv
// Constants and types for the flash command and status unit
// How it works
// - Status bits 3,1,0 read zero, writes ignored
// - Bit 7 write-one launches and clears it; sets on buffer transfer
// - Only burst program may queue, and only behind a running burst
// - Complete flag: buffer empty, idle; clears on launch
// - Protected program/erase sets bit 5, dropped
// - Sequence, divider, stop errors set bit 4
// - Access error cleared by writing one only
// - Blank check pass sets bit 2; launch clears
// - Codes 05 blank check, 20 byte program
// - Codes 25 burst, 40 page, 41 mass erase
// - Other codes are illegal, raise access error
// - Blank check pass makes security state 10
package fcsu_pkg;
    localparam logic [4:0] OFS_STATUS  = 5'h00;
    localparam logic [4:0] OFS_COMMAND = 5'h04;
    localparam logic [4:0] OFS_IRQSTAT = 5'h08;
    localparam logic [4:0] OFS_IRQMASK = 5'h0c;
    localparam logic [4:0] OFS_DIVIDER = 5'h10;
    localparam logic [4:0] OFS_ADDRESS = 5'h14;
    localparam logic [4:0] OFS_DATA    = 5'h18;
    localparam logic [4:0] OFS_PROTECT = 5'h1c;
    localparam int BIT_CBEF  = 7;
    localparam int BIT_CCF   = 6;
    localparam int BIT_PVIOL = 5;
    localparam int BIT_ACCER = 4;
    localparam int BIT_BLANK = 2;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_PVIOL = 1;
    localparam int IRQ_ACCER = 2;
    localparam int PROT_EN   = 8;
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_BYTE  = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE  = 8'h40;
    localparam logic [7:0] CMD_MASS  = 8'h41;
    localparam logic [1:0] SEC_RESET = 2'h3;
    localparam logic [1:0] SEC_OPEN  = 2'h2;
    localparam logic [8:0] PROT_RESET = 9'h000;
    typedef enum logic {FCSU_IDLE, FCSU_RUN} fcsu_state_e;
endpackage : fcsu_pkg

//--- design/fcsu_flash_cmd.sv
// Command launch, buffering and status flags with a Wishbone slave
`timescale 1ns/100ps
module fcsu_flash_cmd #(
    parameter int ADDR_W = 16
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [4:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              stopMode,
    input  wire logic              arrayDone,
    input  wire logic              arrayBlankOk,
    output logic                   arrayStart,
    output logic      [7:0]        arrayCmd,
    output logic      [ADDR_W-1:0] arrayAddr,
    output logic      [7:0]        arrayData,
    output logic      [1:0]        securityState,
    output logic                   irq
);
    initial
    begin
        if (ADDR_W < 9 || ADDR_W > 24)
            $error("ADDR_W must be 9 to 24");
    end

    fcsu_pkg::fcsu_state_e state;
    logic              cbef;
    logic              ccf;
    logic              pviol;
    logic              accErr;
    logic              blank;
    logic [7:0]        cmdReg;
    logic [ADDR_W-1:0] addrReg;
    logic [7:0]        dataReg;
    logic              cmdLoaded;
    logic              divInit;
    logic [7:0]        divider;
    logic [8:0]        protReg;
    logic [2:0]        irqStat;
    logic [2:0]        irqMask;
    logic              stopS1;
    logic              stopS2;
    logic              stopS3;
    logic              stopLvl;
    logic              stopPrev;

    function automatic logic isLegal(input logic [7:0] c);
        return c == fcsu_pkg::CMD_BLANK || c == fcsu_pkg::CMD_BYTE
            || c == fcsu_pkg::CMD_BURST || c == fcsu_pkg::CMD_PAGE
            || c == fcsu_pkg::CMD_MASS;
    endfunction : isLegal

    function automatic logic modifies(input logic [7:0] c);
        return c != fcsu_pkg::CMD_BLANK;
    endfunction : modifies

    logic wbWr;
    logic wbRd;
    logic launchReq;
    logic busy;
    logic protHit;
    logic seqBad;
    logic launchOk;
    logic launchPv;
    logic launchAe;
    logic stopHit;
    logic transfer;
    logic finish;
    logic [7:0] wrByte;

    // Bus side acts on the first cycle; ack follows one edge later
    assign wbWr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    assign wbRd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    assign wrByte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
    assign launchReq = wbWr && wb_adr_i == fcsu_pkg::OFS_STATUS
                    && wrByte[fcsu_pkg::BIT_CBEF] && cbef;
    assign busy = state == fcsu_pkg::FCSU_RUN;
    // Protected region runs from the boundary page to the top
    assign protHit = protReg[fcsu_pkg::PROT_EN]
        && (cmdReg == fcsu_pkg::CMD_MASS
            || addrReg[ADDR_W-1 -: 8] >= protReg[7:0]);
    // A burst program in flight only lets a further burst program queue
    assign seqBad = !cmdLoaded
        || (busy && !(cmdReg == fcsu_pkg::CMD_BURST
                      && arrayCmd == fcsu_pkg::CMD_BURST));
    assign launchAe = launchReq && (seqBad || !isLegal(cmdReg)
        || (modifies(cmdReg) && !divInit));
    assign launchPv = launchReq && !launchAe && modifies(cmdReg)
        && protHit;
    assign launchOk = launchReq && !launchAe && !launchPv;
    assign stopHit = stopLvl && !stopPrev && (busy || !cbef);
    assign transfer = !cbef && !stopHit
        && (state == fcsu_pkg::FCSU_IDLE || finish);
    assign finish = busy && arrayDone;

    // Stop request comes from outside the clock domain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stopS1   <= 1'b0;
            stopS2   <= 1'b0;
            stopS3   <= 1'b0;
            stopLvl  <= 1'b0;
            stopPrev <= 1'b0;
        end
        else
        begin
            stopS1 <= stopMode;
            stopS2 <= stopS1;
            stopS3 <= stopS2;
            if (stopS2 == stopS3)
                stopLvl <= stopS3;
            stopPrev <= stopLvl;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wbRd)
            begin
                unique case (wb_adr_i)
                    fcsu_pkg::OFS_STATUS:
                        wb_dat_o <= {24'h000000, cbef, ccf, pviol,
                                     accErr, 1'b0, blank, 2'b00};
                    fcsu_pkg::OFS_COMMAND:
                        wb_dat_o <= {24'h000000, cmdReg};
                    fcsu_pkg::OFS_IRQSTAT:
                        wb_dat_o <= {29'h0, irqStat};
                    fcsu_pkg::OFS_IRQMASK:
                        wb_dat_o <= {29'h0, irqMask};
                    fcsu_pkg::OFS_DIVIDER:
                        wb_dat_o <= {23'h0, divInit, divider};
                    fcsu_pkg::OFS_ADDRESS:
                        wb_dat_o <= {{(32-ADDR_W){1'b0}}, addrReg};
                    fcsu_pkg::OFS_DATA:
                        wb_dat_o <= {24'h000000, dataReg};
                    fcsu_pkg::OFS_PROTECT:
                        wb_dat_o <= {21'h0, securityState, protReg};
                    default:
                        wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Command words are only taken while the buffer is free
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmdReg    <= 8'h00;
            addrReg   <= '0;
            dataReg   <= 8'h00;
            cmdLoaded <= 1'b0;
            divider   <= 8'h00;
            divInit   <= 1'b0;
            protReg   <= fcsu_pkg::PROT_RESET;
        end
        else
        begin
            if (launchReq)
                cmdLoaded <= 1'b0;
            if (wbWr && cbef && wb_sel_i[0])
            begin
                if (wb_adr_i == fcsu_pkg::OFS_COMMAND)
                begin
                    cmdReg    <= wb_dat_i[7:0];
                    cmdLoaded <= 1'b1;
                end
                if (wb_adr_i == fcsu_pkg::OFS_DATA)
                    dataReg <= wb_dat_i[7:0];
            end
            if (wbWr && cbef && wb_adr_i == fcsu_pkg::OFS_ADDRESS)
                addrReg <= wb_dat_i[ADDR_W-1:0];
            if (wbWr && wb_sel_i[0] && wb_adr_i == fcsu_pkg::OFS_DIVIDER)
            begin
                divider <= wb_dat_i[7:0];
                divInit <= 1'b1;
            end
            if (wbWr && wb_adr_i == fcsu_pkg::OFS_PROTECT)
                protReg <= wb_dat_i[8:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cbef <= 1'b1;
        else if (launchOk)
            cbef <= 1'b0;
        else if (transfer || stopHit)
            cbef <= 1'b1;
    end

    // Array sequencer; a stop abandons the running operation
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= fcsu_pkg::FCSU_IDLE;
            arrayStart <= 1'b0;
            arrayCmd   <= 8'h00;
            arrayAddr  <= '0;
            arrayData  <= 8'h00;
        end
        else
        begin
            arrayStart <= transfer;
            if (stopHit)
                state <= fcsu_pkg::FCSU_IDLE;
            else if (transfer)
            begin
                state     <= fcsu_pkg::FCSU_RUN;
                arrayCmd  <= cmdReg;
                arrayAddr <= addrReg;
                arrayData <= dataReg;
            end
            else if (finish)
                state <= fcsu_pkg::FCSU_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ccf <= 1'b1;
        else if (launchOk)
            ccf <= 1'b0;
        else
            ccf <= cbef && !busy;
    end

    // Error flags: a set in the same cycle beats the clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pviol  <= 1'b0;
            accErr <= 1'b0;
        end
        else
        begin
            if (launchPv)
                pviol <= 1'b1;
            else if (wbWr && wb_adr_i == fcsu_pkg::OFS_STATUS
                     && wrByte[fcsu_pkg::BIT_PVIOL])
                pviol <= 1'b0;
            if (launchAe || stopHit)
                accErr <= 1'b1;
            else if (wbWr && wb_adr_i == fcsu_pkg::OFS_STATUS
                     && wrByte[fcsu_pkg::BIT_ACCER])
                accErr <= 1'b0;
        end
    end

    // Security only ever opens here; a reset restores the default
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blank         <= 1'b0;
            securityState <= fcsu_pkg::SEC_RESET;
        end
        else if (launchOk)
            blank <= 1'b0;
        else if (finish && arrayCmd == fcsu_pkg::CMD_BLANK && arrayBlankOk)
        begin
            blank         <= 1'b1;
            securityState <= fcsu_pkg::SEC_OPEN;
        end
    end

    logic [2:0] irqSet;
    logic [2:0] irqClr;
    assign irqSet = {launchAe || stopHit, launchPv, !ccf && cbef && !busy};
    assign irqClr = (wbWr && wb_adr_i == fcsu_pkg::OFS_IRQSTAT)
                  ? wb_dat_i[2:0] : 3'h0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqStat <= 3'h0;
            irqMask <= 3'h0;
            irq     <= 1'b0;
        end
        else
        begin
            irqStat <= (irqStat & ~irqClr) | irqSet;
            if (wbWr && wb_adr_i == fcsu_pkg::OFS_IRQMASK)
                irqMask <= wb_dat_i[2:0];
            irq <= |(irqStat & irqMask);
        end
    end

    status_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        wbRd && wb_adr_i == fcsu_pkg::OFS_STATUS |=> wb_dat_o[3] == 1'b0
        && wb_dat_o[1:0] == 2'b00) else $error("reserved bits set");
    launch_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        launchOk |=> !cbef && !ccf && !blank)
        else $error("launch left flags set");
    queue_burst_a: assert property (@(posedge clk) disable iff (!rst_n)
        launchOk && busy |-> cmdReg == fcsu_pkg::CMD_BURST)
        else $error("non-burst command queued");
    done_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        cbef && !busy && !launchOk |=> ccf)
        else $error("complete flag missing");
    prot_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        launchPv |=> pviol && cbef && !arrayStart)
        else $error("protected command ran");
    illegal_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        launchReq && !isLegal(cmdReg) |=> accErr && cbef)
        else $error("illegal code accepted");
    err_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        accErr && !(wbWr && wrByte[fcsu_pkg::BIT_ACCER]) |=> accErr)
        else $error("access error lost");
    blank_sec_a: assert property (@(posedge clk) disable iff (!rst_n)
        finish && arrayCmd == fcsu_pkg::CMD_BLANK && arrayBlankOk
        |=> blank && securityState == fcsu_pkg::SEC_OPEN)
        else $error("blank pass not recorded");
    stop_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
        stopHit |=> accErr && !busy ##1 ccf)
        else $error("stop did not abort");
endmodule : fcsu_flash_cmd

//--- test/tb_top.sv
// Self-checking bench for the flash command and status unit
`timescale 1ns/100ps
module tb_top;
    localparam logic [4:0] ST = fcsu_pkg::OFS_STATUS;
    localparam logic [4:0] CM = fcsu_pkg::OFS_COMMAND;
    localparam logic [4:0] IS = fcsu_pkg::OFS_IRQSTAT;
    localparam logic [4:0] IM = fcsu_pkg::OFS_IRQMASK;
    localparam logic [4:0] AD = fcsu_pkg::OFS_ADDRESS;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR;
    logic        ack;
    logic        stopMode = 1'b0;
    logic        arrayDone = 1'b0;
    logic        blankOk = 1'b0;
    logic        arrayStart;
    logic [7:0]  arrayCmd;
    logic [15:0] arrayAddr;
    logic [7:0]  arrayData;
    logic [7:0]  lastCmd;
    logic [1:0]  securityState;
    logic        irq;
    logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    int          errTotal = 0;
    int          nCompared = 0;
    int          starts = 0;
    int          dones = 0;
    int          cycles = 0;

    fcsu_flash_cmd #(.ADDR_W(16)) dut (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
        .stopMode(stopMode), .arrayDone(arrayDone),
        .arrayBlankOk(blankOk), .arrayStart(arrayStart),
        .arrayCmd(arrayCmd), .arrayAddr(arrayAddr), .arrayData(arrayData),
        .securityState(securityState), .irq(irq));

    always #12.5 clk = ~clk;

    // Counts issued operations so each can be answered exactly once
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (arrayStart === 1'b1)
        begin
            starts <= starts + 1;
            lastCmd <= arrayCmd;
        end
        if (cycles == 20000)
        begin
            errTotal++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        if (errTotal == 0 && nCompared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic [4:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1);
        q = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask : chk_rd

    // Command has to be rewritten before every launch
    task automatic la(input logic [7:0] c);
        wr(CM, {24'h0, c});
        wr(ST, 32'h80);
    endtask : la

    task automatic fin(input logic ok, input logic [7:0] c);
        while (starts == dones) @(posedge clk);
        chk({24'h0, lastCmd}, {24'h0, c});
        @(posedge clk);
        arrayDone <= 1'b1;
        blankOk <= ok;
        @(posedge clk);
        arrayDone <= 1'b0;
        blankOk <= 1'b0;
        dones++;
        repeat (3) @(posedge clk);
    endtask : fin

    task automatic t_flags;
        chk_rd(ST, 32'hc0);
        chk({30'h0, securityState}, {30'h0, fcsu_pkg::SEC_RESET});
        la(fcsu_pkg::CMD_BYTE);
        chk_rd(ST, 32'hd0);
        wr(ST, 32'h00);
        chk_rd(ST, 32'hd0);
        wr(ST, 32'h5f);
        chk_rd(ST, 32'hc0);
        wr(fcsu_pkg::OFS_DIVIDER, 32'h1);
        chk_rd(fcsu_pkg::OFS_DIVIDER, 32'h101);
        wr(5'h1e, 32'hffff);
        chk_rd(5'h1e, 32'h0);
        la(8'h33);
        chk_rd(ST, 32'hd0);
        wr(ST, 32'h10);
    endtask : t_flags

    task automatic t_codes;
        wr(IM, 32'h7);
        wr(AD, 32'h0100);
        wr(fcsu_pkg::OFS_DATA, 32'h5a);
        foreach (codes[i])
        begin
            la(codes[i]);
            fin(1'b0, codes[i]);
            chk_rd(ST, 32'hc0);
        end
        // Programming straight after a mass erase needs no blank check
        la(fcsu_pkg::CMD_BYTE);
        fin(1'b0, fcsu_pkg::CMD_BYTE);
        chk({16'h0, arrayAddr}, 32'h0100);
        chk({24'h0, arrayData}, 32'h5a);
        chk_rd(AD, 32'h0100);
        chk({31'h0, irq}, 32'h1);
        wr(IS, 32'h7);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_codes

    task automatic t_blank;
        la(fcsu_pkg::CMD_BLANK);
        fin(1'b1, fcsu_pkg::CMD_BLANK);
        chk_rd(ST, 32'hc4);
        chk({30'h0, securityState}, {30'h0, fcsu_pkg::SEC_OPEN});
        la(fcsu_pkg::CMD_BYTE);
        chk_rd(ST, 32'h80);
        fin(1'b0, fcsu_pkg::CMD_BYTE);
    endtask : t_blank

    task automatic t_queue;
        la(fcsu_pkg::CMD_BURST);
        la(fcsu_pkg::CMD_BURST);
        chk_rd(ST, 32'h00);
        fin(1'b0, fcsu_pkg::CMD_BURST);
        chk_rd(ST, 32'h80);
        fin(1'b0, fcsu_pkg::CMD_BURST);
        chk_rd(ST, 32'hc0);
        la(fcsu_pkg::CMD_BYTE);
        la(fcsu_pkg::CMD_PAGE);
        chk_rd(ST, 32'h90);
        fin(1'b0, fcsu_pkg::CMD_BYTE);
        wr(ST, 32'h10);
    endtask : t_queue

    task automatic t_prot;
        wr(IS, 32'h7);
        wr(IM, 32'h2);
        wr(fcsu_pkg::OFS_PROTECT, 32'h180);
        chk_rd(fcsu_pkg::OFS_PROTECT, 32'h580);
        wr(AD, 32'h9000);
        la(fcsu_pkg::CMD_PAGE);
        chk_rd(ST, 32'he0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(ST, 32'h20);
        la(fcsu_pkg::CMD_MASS);
        chk_rd(ST, 32'he0);
        wr(ST, 32'h20);
        wr(IS, 32'h2);
        wr(AD, 32'h0100);
        la(fcsu_pkg::CMD_PAGE);
        fin(1'b0, fcsu_pkg::CMD_PAGE);
        chk_rd(ST, 32'hc0);
        chk({31'h0, irq}, 32'h0);
    endtask : t_prot

    task automatic t_stop;
        logic [31:0] q;
        la(fcsu_pkg::CMD_BYTE);
        @(posedge clk);
        stopMode <= 1'b1;
        repeat (6) @(posedge clk);
        wb(ST, 1'b0, 32'h0, q);
        chk(q & 32'h10, 32'h10);
        stopMode <= 1'b0;
        fin(1'b0, fcsu_pkg::CMD_BYTE);
        wr(ST, 32'h10);
        chk_rd(ST, 32'hc0);
    endtask : t_stop

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_flags();
        t_codes();
        t_blank();
        t_queue();
        t_prot();
        t_stop();
        wrap_up();
    end
endmodule : tb_top
